// File: src/eaau_pkg.sv
// constants, types and register map of the effective address and alignment unit
package eaau_pkg;

    // register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_BASE = 6'h04;
    localparam logic [5:0] OFS_INDEX = 6'h08;
    localparam logic [5:0] OFS_IMM = 6'h0C;
    localparam logic [5:0] OFS_CIA = 6'h10;
    localparam logic [5:0] OFS_LINK = 6'h14;
    localparam logic [5:0] OFS_COUNT = 6'h18;
    localparam logic [5:0] OFS_BYTECNT = 6'h1C;
    localparam logic [5:0] OFS_START = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;
    localparam logic [5:0] OFS_EA = 6'h28;
    localparam logic [5:0] OFS_NEXT = 6'h2C;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [4:0] BOUND_LEN = 5'h10;
    localparam logic [4:0] MULTI_LEN = 5'h04;
    localparam logic [31:0] INSN_LEN = 32'h0000_0004;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [2:0] SIZE_QUAD = 3'h4;

    typedef enum logic [2:0] {
        OP_DATA_D = 3'b000,
        OP_DATA_X = 3'b001,
        OP_BR_I = 3'b010,
        OP_BR_B = 3'b011,
        OP_BR_XL = 3'b100,
        OP_SEQ = 3'b101,
        OP_CACHE = 3'b110,
        OP_TLB = 3'b111
    } eaau_op_t;

    typedef enum logic [1:0] {
        CLS_INT = 2'b00,
        CLS_AUX = 2'b01,
        CLS_MULTI = 2'b10,
        CLS_OTHER = 2'b11
    } eaau_cls_t;

    typedef enum logic [1:0] {
        DEM_NONE = 2'b00,
        DEM_SIZE = 2'b01,
        DEM_WORD = 2'b10,
        DEM_FORCE = 2'b11
    } eaau_dem_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_WAIT = 2'b10
    } eaau_state_t;

    typedef struct packed {
        logic [10:0] rsvd;
        logic [4:0] page_shift;
        logic string_imm;
        logic base_zero;
        logic use_count;
        logic taken;
        logic absolute_addr_flag;
        logic link_update_flag;
        eaau_dem_t demand;
        eaau_cls_t cls;
        logic [2:0] size;
        eaau_op_t op;
    } eaau_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [4:0] len;
    } eaau_piece_t;

endpackage : eaau_pkg

// File: src/eaau_top.sv
// effective address generation, branch targets and access splitting behind an avalon-mm slave
module eaau_top #(
    parameter int REM_W = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output eaau_pkg::eaau_piece_t piece_out,
    input wire logic piece_ready_in,
    output logic busy_out,
    output logic done_out,
    output logic align_exc_out
);

    if (REM_W < 5 || REM_W > 16) begin : g_check
        $error("REM_W must lie between 5 and 16");
    end

    eaau_pkg::eaau_ctrl_t ctrl_reg;
    logic [31:0] base_reg;
    logic [31:0] index_reg;
    logic [31:0] imm_reg;
    logic [31:0] cia_reg;
    logic [31:0] link_reg;
    logic [31:0] count_reg;
    logic [REM_W-1:0] bytecnt_reg;
    logic [31:0] ea_reg;
    logic [31:0] next_reg;
    logic [31:0] rdata_reg;
    logic wait_reg;
    logic busy_reg;
    logic done_reg;
    logic exc_reg;
    eaau_pkg::eaau_state_t state_reg;
    logic [31:0] cur_addr_reg;
    logic [REM_W-1:0] rem_reg;
    eaau_pkg::eaau_piece_t piece_reg;

    // bus decode: a request is answered one cycle after it appears
    wire req = avs_read_in | avs_write_in;
    wire wr_take = avs_write_in & ~wait_reg;
    wire rd_fetch = avs_read_in & wait_reg;
    wire start = wr_take & (avs_address_in == eaau_pkg::OFS_START) & (state_reg == eaau_pkg::ST_IDLE);

    // operand arithmetic
    wire eaau_pkg::eaau_ctrl_t c = ctrl_reg;
    wire is_int = (c.cls == eaau_pkg::CLS_INT);
    wire is_aux = (c.cls == eaau_pkg::CLS_AUX);
    wire is_multi = (c.cls == eaau_pkg::CLS_MULTI);
    wire is_data = (c.op == eaau_pkg::OP_DATA_D) | (c.op == eaau_pkg::OP_DATA_X);
    wire is_branch = (c.op == eaau_pkg::OP_BR_I) | (c.op == eaau_pkg::OP_BR_B) | (c.op == eaau_pkg::OP_BR_XL);
    wire [31:0] base_val = c.base_zero ? 32'h0000_0000 : base_reg;
    wire [31:0] index_val = c.string_imm ? 32'h0000_0000 : index_reg;
    wire [31:0] disp_ext = {{16{imm_reg[15]}}, imm_reg[15:0]};
    wire [31:0] ea_d = base_val + disp_ext;
    wire [31:0] ea_x = base_val + index_val;
    wire [31:0] ea_raw = (c.op == eaau_pkg::OP_DATA_D) ? ea_d : ea_x;

    // integer sizes stop at word, coprocessor sizes at quadword
    wire [2:0] size_max = is_aux ? eaau_pkg::SIZE_QUAD : eaau_pkg::SIZE_WORD;
    wire [2:0] size_eff = (c.size > size_max) ? size_max : c.size;
    wire [4:0] unit_len = 5'h01 << size_eff;
    wire [31:0] low_mask = {27'h0000000, unit_len - 5'h01};
    wire force_align = is_aux & (c.demand == eaau_pkg::DEM_FORCE);
    wire [31:0] ea_data = force_align ? (ea_raw & ~low_mask) : ea_raw;
    wire [5:0] end_ofs = {2'b00, ea_data[3:0]} + {1'b0, unit_len};
    wire crosses = end_ofs > {1'b0, eaau_pkg::BOUND_LEN};
    wire mis_size = |(ea_raw & low_mask);
    wire mis_word = |ea_raw[1:0];
    wire demand_fail = ((c.demand == eaau_pkg::DEM_SIZE) & mis_size) |
        ((c.demand == eaau_pkg::DEM_WORD) & mis_word);
    wire aux_exc = is_aux & (crosses | demand_fail);
    wire [REM_W-1:0] rem_init = is_multi ? bytecnt_reg : REM_W'(unit_len);

    // next piece: integer and multiple classes stop at 16-byte boundaries, others go whole
    wire [4:0] to_bound = eaau_pkg::BOUND_LEN - {1'b0, cur_addr_reg[3:0]};
    wire [4:0] rem_sat = (rem_reg > REM_W'(eaau_pkg::BOUND_LEN)) ? eaau_pkg::BOUND_LEN : rem_reg[4:0];
    wire [4:0] cap = is_multi ? eaau_pkg::MULTI_LEN : unit_len;
    wire [4:0] len_a = (cap < rem_sat) ? cap : rem_sat;
    wire [4:0] len_b = (len_a < to_bound) ? len_a : to_bound;
    wire [4:0] piece_len = (is_int | is_multi) ? len_b : rem_sat;
    wire last_piece = (rem_reg == REM_W'(piece_reg.len));

    // branch targets
    wire [31:0] off_i = {{6{imm_reg[23]}}, imm_reg[23:0], 2'b00};
    wire [31:0] off_b = {{16{imm_reg[13]}}, imm_reg[13:0], 2'b00};
    wire [31:0] br_base = c.absolute_addr_flag ? 32'h0000_0000 : cia_reg;
    wire [31:0] seq_addr = cia_reg + eaau_pkg::INSN_LEN;
    wire [31:0] tgt_i = br_base + off_i;
    wire [31:0] tgt_b = c.taken ? (br_base + off_b) : seq_addr;
    wire [31:0] xl_src = c.use_count ? count_reg : link_reg;
    wire [31:0] tgt_xl = c.taken ? {xl_src[31:2], 2'b00} : seq_addr;
    wire [31:0] tgt_sel = (c.op == eaau_pkg::OP_BR_I) ? tgt_i :
        (c.op == eaau_pkg::OP_BR_B) ? tgt_b :
        (c.op == eaau_pkg::OP_BR_XL) ? tgt_xl : seq_addr;
    // a misaligned instruction address written by software must not leak into a target
    wire [31:0] next_addr = {tgt_sel[31:2], 2'b00};
    wire link_hw = start & is_branch & c.link_update_flag;

    // cache and page operations
    wire [31:0] cache_ea = {ea_x[31:5], 5'h00};
    wire [31:0] page_mask = 32'hFFFF_FFFF << c.page_shift;
    wire [31:0] tlb_ea = ea_x & page_mask;

    // read mux
    wire [31:0] status_word = {29'h0000_0000, exc_reg, done_reg, busy_reg};
    wire [31:0] rd_word =
        (avs_address_in == eaau_pkg::OFS_CTRL) ? ctrl_reg :
        (avs_address_in == eaau_pkg::OFS_BASE) ? base_reg :
        (avs_address_in == eaau_pkg::OFS_INDEX) ? index_reg :
        (avs_address_in == eaau_pkg::OFS_IMM) ? imm_reg :
        (avs_address_in == eaau_pkg::OFS_CIA) ? cia_reg :
        (avs_address_in == eaau_pkg::OFS_LINK) ? link_reg :
        (avs_address_in == eaau_pkg::OFS_COUNT) ? count_reg :
        (avs_address_in == eaau_pkg::OFS_BYTECNT) ? 32'(bytecnt_reg) :
        (avs_address_in == eaau_pkg::OFS_STATUS) ? status_word :
        (avs_address_in == eaau_pkg::OFS_EA) ? ea_reg :
        (avs_address_in == eaau_pkg::OFS_NEXT) ? next_reg : 32'h0000_0000;

    // bus handshake
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wait_reg <= 1'b1;
            rdata_reg <= eaau_pkg::RST_WORD;
        end else begin
            wait_reg <= ~(req & wait_reg);
            if (rd_fetch) begin
                rdata_reg <= rd_word;
            end
        end
    end

    // software registers; config writes while busy would corrupt a split in flight
    wire cfg_wr = wr_take & ~busy_reg;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_reg <= eaau_pkg::RST_WORD;
            base_reg <= eaau_pkg::RST_WORD;
            index_reg <= eaau_pkg::RST_WORD;
            imm_reg <= eaau_pkg::RST_WORD;
            cia_reg <= eaau_pkg::RST_WORD;
            count_reg <= eaau_pkg::RST_WORD;
            bytecnt_reg <= '0;
        end else if (cfg_wr) begin
            unique case (avs_address_in)
                eaau_pkg::OFS_CTRL: ctrl_reg <= {11'h000, avs_writedata_in[20:0]};
                eaau_pkg::OFS_BASE: base_reg <= avs_writedata_in;
                eaau_pkg::OFS_INDEX: index_reg <= avs_writedata_in;
                eaau_pkg::OFS_IMM: imm_reg <= avs_writedata_in;
                eaau_pkg::OFS_CIA: cia_reg <= avs_writedata_in;
                eaau_pkg::OFS_COUNT: count_reg <= avs_writedata_in;
                eaau_pkg::OFS_BYTECNT: bytecnt_reg <= avs_writedata_in[REM_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            link_reg <= eaau_pkg::RST_WORD;
        end else if (link_hw) begin
            link_reg <= seq_addr;
        end else if (cfg_wr & (avs_address_in == eaau_pkg::OFS_LINK)) begin
            link_reg <= avs_writedata_in;
        end
    end

    // operation sequencer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= eaau_pkg::ST_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            exc_reg <= 1'b0;
            ea_reg <= eaau_pkg::RST_WORD;
            next_reg <= eaau_pkg::RST_WORD;
            cur_addr_reg <= eaau_pkg::RST_WORD;
            rem_reg <= '0;
            piece_reg <= '0;
        end else begin
            unique case (state_reg)
                eaau_pkg::ST_IDLE: begin
                    if (start) begin
                        done_reg <= 1'b0;
                        exc_reg <= 1'b0;
                        if (is_data) begin
                            ea_reg <= ea_data;
                            cur_addr_reg <= ea_data;
                            rem_reg <= rem_init;
                            if (aux_exc) begin
                                exc_reg <= 1'b1;
                                done_reg <= 1'b1;
                            end else if (rem_init == '0) begin
                                done_reg <= 1'b1;
                            end else begin
                                busy_reg <= 1'b1;
                                state_reg <= eaau_pkg::ST_LOAD;
                            end
                        end else if (c.op == eaau_pkg::OP_CACHE) begin
                            ea_reg <= cache_ea;
                            done_reg <= 1'b1;
                        end else if (c.op == eaau_pkg::OP_TLB) begin
                            ea_reg <= tlb_ea;
                            done_reg <= 1'b1;
                        end else begin
                            next_reg <= next_addr;
                            done_reg <= 1'b1;
                        end
                    end
                end
                eaau_pkg::ST_LOAD: begin
                    piece_reg.valid <= 1'b1;
                    piece_reg.addr <= cur_addr_reg;
                    piece_reg.len <= piece_len;
                    state_reg <= eaau_pkg::ST_WAIT;
                end
                eaau_pkg::ST_WAIT: begin
                    if (piece_ready_in) begin
                        piece_reg.valid <= 1'b0;
                        // plain 32-bit add carries an operand over the top to zero
                        cur_addr_reg <= cur_addr_reg + {27'h0000000, piece_reg.len};
                        rem_reg <= rem_reg - REM_W'(piece_reg.len);
                        if (last_piece) begin
                            busy_reg <= 1'b0;
                            done_reg <= 1'b1;
                            state_reg <= eaau_pkg::ST_IDLE;
                        end else begin
                            state_reg <= eaau_pkg::ST_LOAD;
                        end
                    end
                end
                default: state_reg <= eaau_pkg::ST_IDLE;
            endcase
        end
    end

    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign piece_out = piece_reg;
    assign busy_out = busy_reg;
    assign done_out = done_reg;
    assign align_exc_out = exc_reg;

endmodule : eaau_top

// File: dv/eaau_top_assertions.sv
// checker for the bus handshake and the access piece stream
module eaau_top_assertions #(
    parameter int REM_W = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire eaau_pkg::eaau_piece_t piece_out,
    input wire logic piece_ready_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic align_exc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic acc = piece_out.valid && piece_ready_in;
    logic prev_reg;
    logic [31:0] end_reg;
    // end of the last accepted piece, forgotten once the sequence ends
    always_ff @(posedge clk_in) begin
        prev_reg <= !rst_in && busy_out && (prev_reg || acc);
        end_reg <= acc ? piece_out.addr + 32'(piece_out.len) : end_reg;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_ans; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_ans: assert property (p_ans) else $error("request not answered");
    property p_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_one: assert property (p_one) else $error("waitrequest low too long");
    property p_hold; piece_out.valid && !piece_ready_in |=> piece_out.valid && $stable(piece_out); endproperty
    a_hold: assert property (p_hold) else $error("piece changed before acceptance");
    property p_drop; acc |=> !piece_out.valid; endproperty
    a_drop: assert property (p_drop) else $error("piece kept after acceptance");
    property p_len; piece_out.valid |-> piece_out.len inside {[5'h01:5'h10]}; endproperty
    a_len: assert property (p_len) else $error("piece length out of range");
    property p_asc; $rose(piece_out.valid) && prev_reg |-> piece_out.addr == end_reg; endproperty
    a_asc: assert property (p_asc) else $error("piece not contiguous");
    property p_vb; piece_out.valid |-> busy_out && !done_out; endproperty
    a_vb: assert property (p_vb) else $error("piece outside busy");
    property p_fin; $fell(busy_out) |-> done_out && $past(acc); endproperty
    a_fin: assert property (p_fin) else $error("busy ended without final piece");
    property p_exc; align_exc_out |-> done_out && !busy_out; endproperty
    a_exc: assert property (p_exc) else $error("exception while busy");
    c_split: cover property (acc ##2 piece_out.valid);
    c_stall: cover property ((piece_out.valid && !piece_ready_in) [*3]);
    c_exc: cover property ($rose(align_exc_out));
endmodule : eaau_top_assertions

bind eaau_top eaau_top_assertions #(.REM_W(REM_W)) chk_u (.clk_in, .rst_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .piece_out, .piece_ready_in, .busy_out, .done_out, .align_exc_out);

// File: dv/eaau_lsp_model.sv
// load/store path model: takes each piece after a set number of stall cycles
module eaau_lsp_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire eaau_pkg::eaau_piece_t piece_in,
    input wire logic [3:0] stall_in,
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    // ready only toward a valid piece, so no acceptance leaks into idle cycles
    assign ready_out = piece_in.valid && wait_reg >= stall_in;
    always_ff @(posedge clk_in) begin
        if (rst_in || !piece_in.valid || ready_out) begin
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : eaau_lsp_model

// File: dv/eaau_top_bench.sv
// bench: register-level scenarios for the address unit against a stalling load/store model
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module eaau_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdo;
    logic [31:0] rv;
    logic wreq;
    logic busy;
    logic done;
    logic exc;
    logic rdy;
    logic [3:0] stall = 4'h0;
    eaau_pkg::eaau_piece_t pc;
    eaau_pkg::eaau_piece_t pq[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    always #2 clk_in = ~clk_in;
    eaau_top #(.REM_W(8)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdo), .avs_waitrequest_out(wreq),
        .piece_out(pc), .piece_ready_in(rdy), .busy_out(busy), .done_out(done), .align_exc_out(exc));
    eaau_lsp_model lsp_u (.clk_in(clk_in), .rst_in(rst_in), .piece_in(pc), .stall_in(stall), .ready_out(rdy));
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    // pieces are logged at the edge that accepts them
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (pc.valid === 1'b1 && rdy === 1'b1) begin
            pq.push_back(pc);
        end
        if (cyc == 40000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk_in);
        while (wreq !== 1'b0) begin
            @(posedge clk_in);
        end
        rv = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_in);
    endtask : bus
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rv)
    endtask : rchk
    function automatic logic [31:0] dc(input logic [2:0] o, s, input logic [1:0] k, d);
        return {22'h0, d, k, s, o};
    endfunction : dc
    // loads the config block, starts, then polls until done
    task automatic op(input logic [31:0] c, b, x, i, p, l = 32'h0, n = 32'h0, y = 32'h0);
        logic [31:0] v[8];
        v = '{c, b, x, i, p, l, n, y};
        pq.delete();
        foreach (v[k]) begin
            bus(1'b1, 6'(4 * k), v[k]);
        end
        bus(1'b1, 6'h20, 32'h0);
        rv = 32'h0;
        while (rv[1] !== 1'b1) begin
            bus(1'b0, 6'h24, 32'h0);
        end
    endtask : op
    task automatic chk_pc(input logic [31:0] a, input int cnt, input logic [4:0] l0, input int tot);
        int s;
        s = 0;
        `CHK("pieces", cnt, pq.size())
        foreach (pq[k]) begin
            `CHK("piece addr", a, pq[k].addr)
            a = a + 32'(pq[k].len);
            s = s + int'(pq[k].len);
        end
        `CHK("bytes", tot, s)
        if (cnt > 0) `CHK("first len", l0, pq[0].len)
    endtask : chk_pc
    task automatic t_regs();
        rchk(6'h24, 32'h0);
        bus(1'b1, 6'h30, 32'hFFFF_FFFF);
        rchk(6'h30, 32'h0);
        bus(1'b1, 6'h00, 32'hFFFF_FFFF);
        rchk(6'h00, 32'h001F_FFFF);
    endtask : t_regs
    // entry: size, class, pieces, first length, bytes, address
    task automatic t_int();
        logic [31:0] t[6];
        logic [31:0] a;
        t = '{32'h1021_021F, 32'h1012_021E, 32'h2022_042E, 32'h2014_042C, 32'h2023_042D, 32'h2314_042E};
        foreach (t[k]) begin
            a = {24'h400000, t[k][7:0]};
            stall <= 4'(k);
            op(dc(3'h0, t[k][30:28], t[k][25:24], 2'h0), a, 32'h0, 32'h0, 32'h0);
            chk_pc(a, int'(t[k][23:20]), 5'(t[k][19:16]), int'(t[k][15:8]));
        end
    endtask : t_int
    task automatic t_wrap();
        op(dc(3'h0, 3'h2, 2'h0, 2'h0), 32'hFFFF_FF00, 32'h0, 32'hFE, 32'h0);
        chk_pc(32'hFFFF_FFFE, 2, 5'h02, 4);
        op(32'h4000, 32'h1234, 32'h0, 32'hFFFC, 32'h0);
        rchk(6'h28, 32'hFFFF_FFFC);
        chk_pc(32'hFFFF_FFFC, 1, 5'h01, 1);
    endtask : t_wrap
    task automatic t_multi();
        stall <= 4'h5;
        op(32'h81, 32'h1000, 32'h6, 32'h0, 32'h0, 32'h0, 32'h0, 32'hD);
        chk_pc(32'h1006, 4, 5'h04, 13);
        op(32'h8081, 32'h2003, 32'h55, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1);
        chk_pc(32'h2003, 1, 5'h01, 1);
    endtask : t_multi
    // entry: size, demand, exception, aligned address, address
    task automatic t_aux();
        logic [31:0] t[12];
        logic [31:0] a;
        t = '{32'h1010_001F, 32'h2010_001D, 32'h2000_1C1C, 32'h3010_0019, 32'h3000_1818, 32'h4010_0021,
            32'h4000_2020, 32'h2110_001A, 32'h1210_001A, 32'h1100_1A1A, 32'h4300_202F, 32'h3300_282F};
        foreach (t[k]) begin
            a = {24'h500000, t[k][7:0]};
            op(dc(3'h0, t[k][30:28], 2'h1, t[k][25:24]), a, 32'h0, 32'h0, 32'h0);
            `CHK("exception", t[k][20], rv[2])
            `CHK("exc pin", t[k][20], exc)
            `CHK("done pin", 1'b1, done)
            `CHK("busy pin", 1'b0, busy)
            if (t[k][20] == 1'b0) begin
                chk_pc({24'h500000, t[k][15:8]}, 1, 5'h01 << t[k][30:28], 1 << t[k][30:28]);
            end else begin
                chk_pc(a, 0, 5'h00, 0);
            end
        end
    endtask : t_aux
    task automatic t_br();
        op(32'h402, 32'h0, 32'h0, 32'hFF_FFFF, 32'h100);
        rchk(6'h2C, 32'hFC);
        rchk(6'h14, 32'h104);
        op(32'h802, 32'h0, 32'h0, 32'h10, 32'h100, 32'h77);
        rchk(6'h2C, 32'h40);
        rchk(6'h14, 32'h77);
        op(32'h1003, 32'h0, 32'h0, 32'h2000, 32'h8000);
        rchk(6'h2C, 32'h0);
        op(32'h403, 32'h0, 32'h0, 32'h10, 32'hFFFF_FFFC, 32'h55);
        rchk(6'h2C, 32'h0);
        rchk(6'h14, 32'h0);
        op(32'h1004, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1234_5677);
        rchk(6'h2C, 32'h1234_5674);
        op(32'h3004, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'hB);
        rchk(6'h2C, 32'h8);
        op(32'h5, 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFC);
        rchk(6'h2C, 32'h0);
        op(32'h4, 32'h0, 32'h0, 32'h0, 32'h200, 32'h1234_0000);
        rchk(6'h2C, 32'h204);
        op(32'h1803, 32'h0, 32'h0, 32'h10, 32'h500);
        rchk(6'h2C, 32'h40);
    endtask : t_br
    task automatic t_mgmt();
        op(32'h6, 32'h1234_5600, 32'h7F, 32'h0, 32'h0);
        rchk(6'h28, 32'h1234_5660);
        `CHK("pieces", 0, pq.size())
        op(32'h000C_0007, 32'hABCD_E000, 32'hFFF, 32'h0, 32'h0);
        rchk(6'h28, 32'hABCD_E000);
    endtask : t_mgmt
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_int();
        t_wrap();
        t_multi();
        t_aux();
        t_br();
        t_mgmt();
        test_done();
    end
endmodule : eaau_top_bench
